// File: acq_run_ctrl.sv
// run/stop control of a two-section acquisition with an AHB-Lite register slave
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "acq_cfg.svh"
module acq_run_ctrl #(
    parameter int DW = 16,
    parameter int CW = 16
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst,
    // AHB-Lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    // sequencer and recogniser side
    input  wire logic          qual_tick,
    input  wire logic          main_trig_cmd,
    input  wire logic          aux_trig_cmd,
    input  wire logic          direct_test_jump,
    input  wire logic          count_event,
    input  wire logic          aux_wr,
    input  wire logic          aux_sample_tick,
    // run outputs
    output logic               running,
    output logic               acq_enable,
    output logic               counters_run,
    output logic               main_capture_en,
    output logic               aux_capture_en,
    output logic               main_keep,
    output logic               aux_keep,
    output logic               irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave

    logic [7:0]             addr_q;
    logic                   wr_pend;
    logic                   rd_wait;
    logic [`CTRL_W-1:0]     ctrl;
    logic [DW-1:0]          main_delay;
    logic [DW-1:0]          aux_delay;
    logic [`IRQ_W-1:0]      irq_stat;
    logic [`IRQ_W-1:0]      irq_mask;
    logic [CW-1:0]          ev_count;
    wire                    addr_phase;
    wire                    wr_ctrl;
    wire                    wr_main_delay;
    wire                    wr_aux_delay;
    wire                    wr_irq_stat;
    wire                    wr_irq_mask;
    wire [31:0]             rd_mux;
    wire [31:0]             status_word;

    // hsize is not checked: only whole-word transfers are supported
    assign addr_phase    = hsel && hready && htrans[1];
    assign wr_ctrl       = wr_pend && (addr_q == `ADDR_CTRL);
    assign wr_main_delay = wr_pend && (addr_q == `ADDR_MAIN_DELAY);
    assign wr_aux_delay  = wr_pend && (addr_q == `ADDR_AUX_DELAY);
    assign wr_irq_stat   = wr_pend && (addr_q == `ADDR_IRQ_STAT);
    assign wr_irq_mask   = wr_pend && (addr_q == `ADDR_IRQ_MASK);
    // reads wait one cycle so a write just before is already visible
    assign hreadyout     = !rd_wait;
    assign hresp         = `HRESP_OKAY;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_pend <= 1'b0;
            rd_wait <= 1'b0;
            addr_q  <= 8'h00;
        end else begin
            wr_pend <= addr_phase && hwrite;
            rd_wait <= addr_phase && !hwrite;
            if (addr_phase) begin
                addr_q <= {haddr[7:2], 2'b00};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_wait) begin
            hrdata <= rd_mux;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl       <= `CTRL_RST;
            main_delay <= DW'(`DELAY_RST);
            aux_delay  <= DW'(`DELAY_RST);
            irq_mask   <= `IRQ_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= hwdata[`CTRL_W-1:0] & `CTRL_WMASK;
            end
            if (wr_main_delay) begin
                main_delay <= hwdata[DW-1:0];
            end
            if (wr_aux_delay) begin
                aux_delay <= hwdata[DW-1:0];
            end
            if (wr_irq_mask) begin
                irq_mask <= hwdata[`IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // run state

    acq_pkg::run_state_t    state;
    acq_pkg::run_state_t    next_state;
    wire                    has_main;
    wire                    has_aux;
    wire                    start_req;
    wire                    stop_req;
    wire                    start_go;
    wire                    complete;
    wire                    run_end;
    wire                    main_trig_live;
    wire                    aux_cmd_live;
    wire                    aux_fire;
    wire                    aux_armed;
    wire                    aux_async;
    wire                    aux_tick;
    wire                    main_triggered;
    wire                    main_done;
    wire                    aux_triggered;
    wire                    aux_done;
    wire [DW-1:0]           main_remain;
    wire [DW-1:0]           aux_remain;
    wire acq_pkg::aux_mode_t aux_mode;

    assign has_main  = ctrl[`CTRL_HAS_MAIN];
    assign has_aux   = ctrl[`CTRL_HAS_AUX];
    assign aux_mode  = acq_pkg::aux_mode_t'(ctrl[`CTRL_AUX_MODE]);
    assign start_req = wr_ctrl && hwdata[`CTRL_START];
    assign stop_req  = wr_ctrl && hwdata[`CTRL_STOP];
    assign running   = (state == acq_pkg::RUN_ACTIVE);
    assign start_go  = !running && (start_req || direct_test_jump);
    // a program with no trigger command never completes on its own
    assign complete  = (has_main || has_aux) && (!has_main || main_done)
                       && (!has_aux || aux_done);
    assign run_end   = running && (stop_req || complete);

    always_comb begin
        next_state = state;
        case (state)
            acq_pkg::RUN_IDLE: begin
                if (start_go) begin
                    next_state = acq_pkg::RUN_ACTIVE;
                end
            end
            acq_pkg::RUN_ACTIVE: begin
                if (run_end) begin
                    next_state = acq_pkg::RUN_IDLE;
                end
            end
            default: begin
                next_state = acq_pkg::RUN_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= acq_pkg::RUN_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // acq_enable and counters_run run for the whole run, trigger or not; a capture enable also needs its keep and drops at its section's done
    assign acq_enable   = running;
    assign counters_run = running;
    assign main_keep    = has_main || !has_aux;
    assign aux_keep     = has_aux;
    assign main_capture_en = running && main_keep && !main_done;
    assign aux_capture_en  = running && aux_keep && !aux_done;

    ////////////////////////////////////////////////////////////////////////////////
    // sections

    // a command from a test never reached simply never arrives here
    assign main_trig_live = running && has_main && main_trig_cmd;
    assign aux_cmd_live   = running && has_aux && aux_trig_cmd;
    assign aux_tick       = aux_async ? aux_sample_tick : qual_tick;

    post_delay #(.W(DW)) u_main_delay (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .clear     (start_go),
        .trig      (main_trig_live),
        .tick      (qual_tick && running),
        .pos       (acq_pkg::trig_pos_t'(ctrl[`CTRL_MAIN_POS])),
        .delay_cnt (main_delay),
        .triggered (main_triggered),
        .done      (main_done),
        .remain    (main_remain)
    );

    aux_trigger u_aux_trig (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .clear       (start_go),
        .enable      (running),
        .cmd         (aux_cmd_live),
        .mode        (aux_mode),
        .wr          (aux_wr),
        .sample_tick (aux_sample_tick),
        .fire        (aux_fire),
        .armed       (aux_armed),
        .is_async    (aux_async)
    );

    post_delay #(.W(DW)) u_aux_delay (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .clear     (start_go),
        .trig      (aux_fire),
        .tick      (aux_tick && running),
        .pos       (acq_pkg::trig_pos_t'(ctrl[`CTRL_AUX_POS])),
        .delay_cnt (aux_delay),
        .triggered (aux_triggered),
        .done      (aux_done),
        .remain    (aux_remain)
    );

    always_ff @(posedge ref_clk) begin
        if (rst || start_go) begin
            ev_count <= CW'(`COUNT_RST);
        end else if (running && count_event) begin
            ev_count <= ev_count + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupts and read mux

    logic                   main_done_q;
    logic                   aux_done_q;
    wire [`IRQ_W-1:0]       irq_event;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            main_done_q <= 1'b0;
            aux_done_q  <= 1'b0;
        end else begin
            main_done_q <= main_done;
            aux_done_q  <= aux_done;
        end
    end

    assign irq_event[`IRQ_RUN_END]   = run_end;
    assign irq_event[`IRQ_MAIN_TRIG] = main_trig_live && !main_triggered;
    assign irq_event[`IRQ_AUX_TRIG]  = aux_fire && !aux_triggered;
    assign irq_event[`IRQ_MAIN_DONE] = main_done && !main_done_q;
    assign irq_event[`IRQ_AUX_DONE]  = aux_done && !aux_done_q;

    // a new event wins over a write-one-to-clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < `IRQ_W; gi = gi + 1) begin : g_irq
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    irq_stat[gi] <= 1'b0;
                end else begin
                    irq_stat[gi] <= irq_event[gi]
                                    || (irq_stat[gi] && !(wr_irq_stat && hwdata[gi]));
                end
            end
        end
    endgenerate

    assign irq = |(irq_stat & irq_mask);

    assign status_word = 32'({aux_armed, aux_done, aux_triggered,
                              main_done, main_triggered, running});
    assign rd_mux = (addr_q == `ADDR_CTRL)       ? 32'(ctrl)       :
                    (addr_q == `ADDR_MAIN_DELAY) ? 32'(main_delay) :
                    (addr_q == `ADDR_AUX_DELAY)  ? 32'(aux_delay)  :
                    (addr_q == `ADDR_STATUS)     ? status_word     :
                    (addr_q == `ADDR_IRQ_STAT)   ? 32'(irq_stat)   :
                    (addr_q == `ADDR_IRQ_MASK)   ? 32'(irq_mask)   :
                    (addr_q == `ADDR_EV_COUNT)   ? 32'(ev_count)   :
                    (addr_q == `ADDR_REMAIN)     ? {16'(aux_remain), 16'(main_remain)} :
                    32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    property p_sync_direct;
        (aux_fire && !aux_async) |-> aux_cmd_live;
    endproperty
    a_sync_direct: assert property (p_sync_direct)
        else $error("sync aux trigger without its command");

    property p_async_arm;
        (running && aux_async && aux_cmd_live && !stop_req && !complete)
            |=> (aux_armed || aux_fire) && !$past(aux_fire);
    endproperty
    a_async_arm: assert property (p_async_arm)
        else $error("async aux command did not just arm");

    property p_async_edge;
        (aux_fire && aux_async) |-> aux_armed && aux_sample_tick
            && (aux_wr == (aux_mode == acq_pkg::AUX_RISE));
    endproperty
    a_async_edge: assert property (p_async_edge)
        else $error("async aux trigger without arming and edge");

    property p_no_cmd_runs;
        (running && !has_main && !has_aux && !stop_req) |=> running;
    endproperty
    a_no_cmd_runs: assert property (p_no_cmd_runs)
        else $error("run ended without stop and no trigger command");

    property p_end_on_complete;
        (running && complete) |=> !running;
    endproperty
    a_end_on_complete: assert property (p_end_on_complete)
        else $error("run did not end when all sections done");

    property p_keep_running;
        (running && !complete && !stop_req) |=> running && acq_enable;
    endproperty
    a_keep_running: assert property (p_keep_running)
        else $error("run ended while a section was outstanding");

    property p_start;
        (!running && (start_req || direct_test_jump)) |=> running;
    endproperty
    a_start: assert property (p_start)
        else $error("start request did not begin a run");

    property p_before_240;
        (main_trig_live && !main_triggered && ctrl[`CTRL_MAIN_POS] == 2'b00)
            |=> main_remain == DW'(`POST_BEFORE);
    endproperty
    a_before_240: assert property (p_before_240)
        else $error("before-data countdown not loaded with 240");

    property p_stop_now;
        (running && stop_req) |=> !running && !acq_enable && !counters_run;
    endproperty
    a_stop_now: assert property (p_stop_now)
        else $error("stop request did not halt the run");

    property p_count_after_trig;
        (running && main_triggered && count_event && !$past(start_go))
            |=> ev_count == $past(ev_count) + 1'b1;
    endproperty
    a_count_after_trig: assert property (p_count_after_trig)
        else $error("counter event lost after trigger");

    c_both_done: cover property (running && has_main && has_aux && complete);
    c_stop_in_delay: cover property (running && main_triggered && !main_done && stop_req);
    c_async_fire: cover property (aux_fire && aux_async);
    c_jump_start: cover property (!running && direct_test_jump);

endmodule

// File: acq_cfg.svh
// register offsets, field positions, reset values and trigger position counts
`ifndef ACQ_CFG_SVH
`define ACQ_CFG_SVH

`define ADDR_CTRL        8'h00
`define ADDR_MAIN_DELAY  8'h04
`define ADDR_AUX_DELAY   8'h08
`define ADDR_STATUS      8'h0c
`define ADDR_IRQ_STAT    8'h10
`define ADDR_IRQ_MASK    8'h14
`define ADDR_EV_COUNT    8'h18
`define ADDR_REMAIN      8'h1c

`define CTRL_START       0
`define CTRL_STOP        1
`define CTRL_HAS_MAIN    2
`define CTRL_HAS_AUX     3
`define CTRL_AUX_MODE    5:4
`define CTRL_MAIN_POS    7:6
`define CTRL_AUX_POS     9:8
`define CTRL_W           10
`define CTRL_WMASK       10'h3fc

`define IRQ_RUN_END      0
`define IRQ_MAIN_TRIG    1
`define IRQ_AUX_TRIG     2
`define IRQ_MAIN_DONE    3
`define IRQ_AUX_DONE     4
`define IRQ_W            5

`define CTRL_RST         10'h000
`define DELAY_RST        16'h0000
`define IRQ_RST          5'h00
`define COUNT_RST        16'h0000

`define POST_BEFORE      16'h00f0
`define POST_CENTER      16'h0080
`define POST_AFTER       16'h0010

`define HRESP_OKAY       1'b0

`endif

// File: acq_pkg.sv
// shared types of the acquisition run control
package acq_pkg;
    typedef enum logic [1:0] {AUX_SYNC, AUX_RISE, AUX_FALL, AUX_RSVD} aux_mode_t;
    typedef enum logic [1:0] {POS_BEFORE, POS_CENTER, POS_AFTER, POS_DELAYED} trig_pos_t;
    typedef enum logic {RUN_IDLE, RUN_ACTIVE} run_state_t;
endpackage

// File: post_delay.sv
// post-trigger delay countdown of one capture section
`timescale 1ns/1ps
`include "acq_cfg.svh"
module post_delay #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // control
    input  wire logic              clear,
    input  wire logic              trig,
    input  wire logic              tick,
    input  wire acq_pkg::trig_pos_t pos,
    input  wire logic [W-1:0]      delay_cnt,
    // state
    output logic                   triggered,
    output logic                   done,
    output logic [W-1:0]           remain
);

    wire [W-1:0] load_val;

    assign load_val = (pos == acq_pkg::POS_BEFORE) ? W'(`POST_BEFORE) :
                      (pos == acq_pkg::POS_CENTER) ? W'(`POST_CENTER) :
                      (pos == acq_pkg::POS_AFTER)  ? W'(`POST_AFTER)  : delay_cnt;

    // a second trigger is ignored: the first one fixes the window
    always_ff @(posedge ref_clk) begin
        if (rst || clear) begin
            triggered <= 1'b0;
            remain    <= W'(`DELAY_RST);
        end else if (trig && !triggered) begin
            triggered <= 1'b1;
            remain    <= load_val;
        end else if (triggered && tick && remain != W'(`DELAY_RST)) begin
            remain    <= remain - 1'b1;
        end
    end

    assign done = triggered && (remain == W'(`DELAY_RST));

endmodule

// File: aux_trigger.sv
// auxiliary section trigger: direct in sync mode, armed edge in async mode
`timescale 1ns/1ps
module aux_trigger (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // control
    input  wire logic              clear,
    input  wire logic              enable,
    input  wire logic              cmd,
    input  wire acq_pkg::aux_mode_t mode,
    // event recogniser
    input  wire logic              wr,
    input  wire logic              sample_tick,
    // result
    output logic                   fire,
    output logic                   armed,
    output logic                   is_async
);

    logic wr_prev;
    wire  rise;
    wire  fall;
    wire  edge_hit;

    assign is_async = (mode == acq_pkg::AUX_RISE) || (mode == acq_pkg::AUX_FALL);
    assign rise     = sample_tick && wr && !wr_prev;
    assign fall     = sample_tick && !wr && wr_prev;
    assign edge_hit = (mode == acq_pkg::AUX_RISE) ? rise : fall;
    // an edge in the arming cycle itself does not count: arming comes first
    assign fire     = enable && (is_async ? (armed && edge_hit) : cmd);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_prev <= 1'b0;
        end else if (sample_tick) begin
            wr_prev <= wr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || clear) begin
            armed <= 1'b0;
        end else begin
            armed <= (armed && !fire) || (enable && is_async && cmd);
        end
    end

endmodule

// File: sut_model.sv
// system under test as seen through the probes: sequencer and recogniser strobes
`timescale 1ns/1ps
module sut_model (
    // clock
    input  wire logic ref_clk,
    // sequencer and recogniser side
    output logic      qual_tick,
    output logic      main_trig_cmd,
    output logic      aux_trig_cmd,
    output logic      direct_test_jump,
    output logic      count_event,
    output logic      aux_wr,
    output logic      aux_sample_tick
);
    initial begin
        {qual_tick, count_event, main_trig_cmd, aux_trig_cmd, direct_test_jump} = '0;
        aux_wr = 1'b0;
        aux_sample_tick = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // strobe set {tick, event, main, aux, jump} for n cycles; ends idle so
    // back-to-back calls never assign one strobe twice in a time step
    task automatic pulse(input logic [4:0] s, input int n);
        repeat (n) begin
            {qual_tick, count_event, main_trig_cmd, aux_trig_cmd, direct_test_jump} <= s;
            @(posedge ref_clk);
        end
        {qual_tick, count_event, main_trig_cmd, aux_trig_cmd, direct_test_jump} <= '0;
        @(posedge ref_clk);
    endtask
    // recogniser level, seen on one sample strobe
    task automatic wr_to(input logic v);
        aux_wr <= v;
        aux_sample_tick <= 1'b1;
        @(posedge ref_clk);
        aux_sample_tick <= 1'b0;
        @(posedge ref_clk);
    endtask
endmodule

// File: test_acq_run_ctrl.sv
// self-checking bench of the run/stop control through its register bus
`timescale 1ns/1ps
`include "acq_cfg.svh"
module test_acq_run_ctrl;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hreadyout, hresp, qual_tick, main_trig_cmd, aux_trig_cmd;
    logic        direct_test_jump, count_event, aux_wr, aux_sample_tick;
    logic        running, acq_enable, counters_run, main_capture_en;
    logic        aux_capture_en, main_keep, aux_keep, irq;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          n;

    always #10 ref_clk = ~ref_clk;

    acq_run_ctrl dut_u (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .qual_tick, .main_trig_cmd,
        .aux_trig_cmd, .direct_test_jump, .count_event, .aux_wr, .aux_sample_tick,
        .running, .acq_enable, .counters_run, .main_capture_en, .aux_capture_en,
        .main_keep, .aux_keep, .irq);
    sut_model sut_u (.ref_clk, .qual_tick, .main_trig_cmd, .aux_trig_cmd,
        .direct_test_jump, .count_event, .aux_wr, .aux_sample_tick);
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single word transfer; read data land in rd
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, '0);
        chk(rd, exp);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // generous bound: the longest run is a few hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rdchk(`ADDR_CTRL, 32'h0000_0000);
        rdchk(8'h20, 32'h0000_0000);
        chk({aux_keep, main_keep, irq}, 32'h0000_0002);
        chk(hresp, 32'h0000_0000);
        xfer(1'b1, `ADDR_IRQ_MASK, 32'h0000_001f);
        xfer(1'b1, `ADDR_MAIN_DELAY, 32'h0000_0005);
        for (int p = 0; p < 4; p++) begin
            n = (p == 0) ? `POST_BEFORE : (p == 1) ? `POST_CENTER : (p == 2) ? `POST_AFTER : 5;
            xfer(1'b1, `ADDR_CTRL, {24'h00_0000, p[1:0], 6'h05});
            sut_u.pulse(5'b00100, 1);
            rdchk(`ADDR_REMAIN, n);
            sut_u.pulse(5'b11000, n - 1);
            chk(running, 1'b1);
            sut_u.pulse(5'b11000, 1);
            repeat (2) @(posedge ref_clk);
            rdchk(`ADDR_STATUS, 32'h0000_0006);
            rdchk(`ADDR_EV_COUNT, n);
            rdchk(`ADDR_IRQ_STAT, 32'h0000_000b);
            chk(irq, 1'b1);
            xfer(1'b1, `ADDR_IRQ_STAT, 32'h0000_001f);
            @(posedge ref_clk);
            chk(irq, 1'b0);
            $display("main position %0d done", p);
        end
        // sync aux via the reserved mode code: recogniser edges alone must not fire it
        xfer(1'b1, `ADDR_AUX_DELAY, 32'h0000_0002);
        xfer(1'b1, `ADDR_CTRL, 32'h0000_0339);
        sut_u.wr_to(1'b1);
        sut_u.wr_to(1'b0);
        rdchk(`ADDR_STATUS, 32'h0000_0001);
        chk({aux_keep, main_keep}, 32'h0000_0002);
        sut_u.pulse(5'b00010, 1);
        rdchk(`ADDR_STATUS, 32'h0000_0009);
        sut_u.pulse(5'b10000, 2);
        repeat (2) @(posedge ref_clk);
        rdchk(`ADDR_STATUS, 32'h0000_0018);
        rdchk(`ADDR_IRQ_STAT, 32'h0000_0015);
        $display("aux sync done");
        xfer(1'b1, `ADDR_AUX_DELAY, 32'h0000_0000);
        for (int m = 1; m < 3; m++) begin
            sut_u.wr_to(m == 1);
            xfer(1'b1, `ADDR_CTRL, {24'h00_0003, 2'h0, m[1:0], 4'h9});
            sut_u.pulse(5'b00010, 1);
            rdchk(`ADDR_STATUS, 32'h0000_0021);
            sut_u.wr_to(m != 1);
            rdchk(`ADDR_STATUS, 32'h0000_0021);
            sut_u.wr_to(m == 1);
            repeat (2) @(posedge ref_clk);
            xfer(1'b0, `ADDR_STATUS, '0);
            chk(rd & 32'h0000_001f, 32'h0000_0018);
            $display("aux async mode %0d done", m);
        end
        xfer(1'b1, `ADDR_MAIN_DELAY, 32'h0000_0000);
        xfer(1'b1, `ADDR_CTRL, 32'h0000_03cd);
        sut_u.pulse(5'b00100, 1);
        repeat (2) @(posedge ref_clk);
        rdchk(`ADDR_STATUS, 32'h0000_0007);
        sut_u.pulse(5'b00010, 1);
        repeat (2) @(posedge ref_clk);
        rdchk(`ADDR_STATUS, 32'h0000_001e);
        $display("both sections done");
        xfer(1'b1, `ADDR_CTRL, 32'h0000_0000);
        sut_u.pulse(5'b00001, 1);
        chk(running, 1'b1);
        sut_u.pulse(5'b11100, 4);
        chk({running, main_capture_en, aux_capture_en}, 32'h0000_0006);
        chk({acq_enable, counters_run}, 32'h0000_0003);
        xfer(1'b1, `ADDR_CTRL, 32'h0000_0002);
        @(posedge ref_clk);
        chk({running, counters_run}, 32'h0000_0000);
        // stop in the middle of a before-data countdown
        xfer(1'b1, `ADDR_CTRL, 32'h0000_0005);
        sut_u.pulse(5'b00100, 1);
        sut_u.pulse(5'b10000, 3);
        xfer(1'b1, `ADDR_CTRL, 32'h0000_0002);
        rdchk(`ADDR_STATUS, 32'h0000_0002);
        rdchk(`ADDR_REMAIN, 32'h0000_00ed);
        $display("jump start and stop done");
        stop_test();
    end
endmodule
